// *** far_side_model.sv ***
`timescale 1ns/1ps
// far party: feeds data under the device clock or clocks data out of it
module far_side_model (
	input wire clk_line,
	input wire data_line,
	output reg clk_drive = 1'b0,
	output reg data_drive = 1'b0,
	output reg data_en = 1'b0
);
	reg [23:0] tx_shift = 24'h000000;
	reg [8:0] rx_shift = 9'h000;
	reg first = 1'b1;
	// next bit on each leading edge but the first
	always @(posedge clk_line) begin
		if (data_en && !first) begin
			tx_shift = tx_shift >> 1;
			data_drive = tx_shift[0];
		end
		first = 1'b0;
	end
	// sample on the trailing edge, lsb first
	always @(negedge clk_line) rx_shift = {data_line, rx_shift[8:1]};
	task load(input [23:0] value);
		tx_shift = value;
		data_drive = value[0];
		data_en = 1'b1;
		first = 1'b1;
	endtask
	// released line shows the inverse, so a stale bit never passes
	task release_data;
		data_en = 1'b0;
		data_drive = ~data_drive;
	endtask
	// clock runs only inside a frame, 160 ns period, off the core phase
	task clock_frame(input integer bits);
		#1.3;
		repeat (bits) begin
			#80 clk_drive = 1'b1;
			#80 clk_drive = 1'b0;
		end
		// let the last trailing-edge sample land before a caller reads it
		#1;
	endtask
endmodule

// *** sync_serial_checker.sv ***
`timescale 1ns/1ps
// port-level watch on bus handshake, clock ownership and request outputs
module sync_serial_checker (
	input wire core_clk,
	input wire rst_n,
	input wire read,
	input wire write,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire shift_clock_pin_out,
	input wire shift_clock_pin_oe_n,
	input wire core_sleep,
	input wire receive_request,
	input wire wake_request,
	input wire vector_request
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	property p_wait_first;
		$rose(read || write) |-> waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait state");
	property p_one_wait;
		waitrequest |=> !waitrequest;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("wait too long");
	property p_idle_wait;
		!(read || write) |-> !waitrequest;
	endproperty
	a_idle_wait: assert property (p_idle_wait) else $error("wait while idle");
	property p_read_width;
		read && !waitrequest |-> readdata[31:8] == 24'h000000;
	endproperty
	a_read_width: assert property (p_read_width) else $error("upper bits set");
	property p_clk_owner;
		!$stable(shift_clock_pin_out) |-> !$past(shift_clock_pin_oe_n);
	endproperty
	a_clk_owner: assert property (p_clk_owner) else $error("clock moved undriven");
	property p_sleep_hold;
		core_sleep && $past(core_sleep) |-> $stable(shift_clock_pin_out);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("clock ran in sleep");
	property p_rx_wake;
		receive_request |-> wake_request;
	endproperty
	a_rx_wake: assert property (p_rx_wake) else $error("rx without wake");
	property p_vector;
		vector_request |-> wake_request;
	endproperty
	a_vector: assert property (p_vector) else $error("vector without wake");
endmodule
bind sync_serial_master_rx_slave_tx sync_serial_checker sync_serial_checker_inst (
	.core_clk(core_clk), .rst_n(rst_n), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .shift_clock_pin_out(shift_clock_pin_out),
	.shift_clock_pin_oe_n(shift_clock_pin_oe_n), .core_sleep(core_sleep),
	.receive_request(receive_request), .wake_request(wake_request),
	.vector_request(vector_request)
);

// *** sync_serial_consts.vh ***
`ifndef SYNC_SERIAL_CONSTS_VH
`define SYNC_SERIAL_CONSTS_VH

// register byte addresses on the register bus
`define ADDR_TX_STATUS_CONTROL 6'h00
`define ADDR_RX_STATUS_CONTROL 6'h04
`define ADDR_BAUD_CONTROL 6'h08
`define ADDR_BAUD_DIVISOR_LOW 6'h0C
`define ADDR_BAUD_DIVISOR_HIGH 6'h10
`define ADDR_RECEIVE_DATA 6'h14
`define ADDR_TRANSMIT_DATA 6'h18
`define ADDR_INTERRUPT_CONTROL 6'h1C

// transmit status/control fields
`define TSC_MASTER_CLOCK_SOURCE 7
`define TSC_NINE_BIT_TX_SELECT 6
`define TSC_TRANSMIT_ENABLE 5
`define TSC_SYNC_SELECT 4
`define TSC_BAUD_HIGH_SPEED 2
`define TSC_SHIFT_EMPTY 1
`define TSC_TRANSMIT_NINTH_BIT 0

// receive status/control fields
`define RSC_SERIAL_PORT_ON 7
`define RSC_NINE_BIT_RX_SELECT 6
`define RSC_SINGLE_RX_ENABLE 5
`define RSC_CONTINUOUS_RX_ENABLE 4
`define RSC_OVERRUN_ERROR 1
`define RSC_RECEIVED_NINTH_BIT 0

// baud control and interrupt control fields
`define BAUD_WIDE_DIVISOR_SELECT 3
`define INT_RECEIVE_ENABLE 0
`define INT_TRANSMIT_ENABLE 1
`define INT_PERIPHERAL_ENABLE 2
`define INT_GLOBAL_ENABLE 3
`define INT_RECEIVE_FLAG 4
`define INT_TRANSMIT_FLAG 5

// writable masks and reset values
`define TSC_WRITE_MASK 8'hFD
`define RSC_WRITE_MASK 8'hF0
`define BAUD_WRITE_MASK 8'h08
`define INT_WRITE_MASK 8'h0F
`define CONTROL_RESET 8'h00
`define TRANSMIT_BUFFER_RESET 9'h000

// character lengths
`define CHAR_BITS_SHORT 4'h8
`define CHAR_BITS_LONG 4'h9

`endif

// *** sync_serial_master_rx_slave_tx.v ***
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "sync_serial_consts.vh"

module sync_serial_master_rx_slave_tx (
	input wire core_clk,
	input wire rst_n,
	input wire [5:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output wire waitrequest,
	input wire shift_clock_pin_in,
	output wire shift_clock_pin_out,
	output wire shift_clock_pin_oe_n,
	input wire shift_data_pin_in,
	output wire shift_data_pin_out,
	output wire shift_data_pin_oe_n,
	input wire core_sleep,
	output wire receive_request,
	output wire wake_request,
	output wire vector_request
);
	reg ack_reg;
	reg [7:0] tsc_reg;
	reg [7:0] rsc_reg;
	reg [7:0] baud_ctl_reg;
	reg [7:0] div_low_reg;
	reg [7:0] div_high_reg;
	reg [7:0] int_ctl_reg;
	reg overrun_reg;
	reg [8:0] fifo_mem [0:1];
	reg rd_ptr_reg;
	reg [1:0] fifo_count_reg;
	reg [8:0] rsr_reg;
	reg [3:0] rx_bits_reg;
	reg [8:0] tx_buf_reg;
	reg tx_buf_full_reg;
	reg [8:0] tsr_reg;
	reg tsr_busy_reg;
	reg tx_first_reg;
	reg [3:0] tx_bits_reg;
	reg mclk_reg;
	reg [15:0] half_cnt_reg;
	reg pin_clk_d_reg;
	wire [1:0] pins_sync;
	wire pin_clk_s;
	wire pin_data_s;

	sync_two_flop #(.WIDTH(2)) pin_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in({shift_clock_pin_in, shift_data_pin_in}),
		.sync_out(pins_sync)
	);
	assign pin_clk_s = pins_sync[1];
	assign pin_data_s = pins_sync[0];

	// mode decode
	wire port_on = rsc_reg[`RSC_SERIAL_PORT_ON];
	wire sync_sel = tsc_reg[`TSC_SYNC_SELECT];
	wire single_receive_enable = rsc_reg[`RSC_SINGLE_RX_ENABLE];
	wire continuous_receive_enable = rsc_reg[`RSC_CONTINUOUS_RX_ENABLE];
	wire master_mode = port_on & sync_sel & tsc_reg[`TSC_MASTER_CLOCK_SOURCE];
	wire slave_mode = port_on & sync_sel & ~tsc_reg[`TSC_MASTER_CLOCK_SOURCE];
	wire rx_mode = single_receive_enable | continuous_receive_enable;
	wire tx_mode = ~rx_mode & tsc_reg[`TSC_TRANSMIT_ENABLE];
	wire rx_on = rx_mode & ~overrun_reg;
	wire [3:0] rx_len = rsc_reg[`RSC_NINE_BIT_RX_SELECT] ? `CHAR_BITS_LONG : `CHAR_BITS_SHORT;
	wire [3:0] tx_len = tsc_reg[`TSC_NINE_BIT_TX_SELECT] ? `CHAR_BITS_LONG : `CHAR_BITS_SHORT;

	// divisor: wide pair or low byte only; sync mode ignores the speed select
	wire [15:0] divisor = baud_ctl_reg[`BAUD_WIDE_DIVISOR_SELECT] ?
		{div_high_reg, div_low_reg} : {8'h00, div_low_reg};

	// master clock runs for reception or a pending transmit; no core clock in sleep
	wire master_run = master_mode & ~core_sleep &
		(rx_on | (tx_mode & tsr_busy_reg));
	wire half_tick = master_run & (half_cnt_reg == 16'h0000);

	// master clock generator; idle low, rising is the leading edge
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mclk_reg <= 1'b0;
			half_cnt_reg <= 16'h0000;
			pin_clk_d_reg <= 1'b0;
		end else begin
			pin_clk_d_reg <= pin_clk_s;
			if (!master_run) begin
				mclk_reg <= 1'b0; // stops at once when reception is dropped
				half_cnt_reg <= divisor;
			end else if (half_tick) begin
				mclk_reg <= ~mclk_reg;
				half_cnt_reg <= divisor;
			end else begin
				half_cnt_reg <= half_cnt_reg - 16'h0001;
			end
		end
	end

	// shift clock edges, from own generator or from the far master
	wire lead_edge = master_mode ? (half_tick & ~mclk_reg) :
		(slave_mode & pin_clk_s & ~pin_clk_d_reg);
	wire trail_edge = master_mode ? (half_tick & mclk_reg) :
		(slave_mode & ~pin_clk_s & pin_clk_d_reg);

	// bus handshake: one wait state, answer on the second cycle
	wire bus_req = read | write;
	assign waitrequest = bus_req & ~ack_reg;
	wire wr_take = write & ack_reg;
	wire rd_take = read & ack_reg;
	wire rd_pop = rd_take & (address == `ADDR_RECEIVE_DATA) & (fifo_count_reg != 2'b00);
	wire wr_tx = wr_take & (address == `ADDR_TRANSMIT_DATA);
	wire wr_rsc = wr_take & (address == `ADDR_RX_STATUS_CONTROL);

	wire receive_complete_flag = (fifo_count_reg != 2'b00);
	wire transmit_buffer_free_flag = ~tx_buf_full_reg;
	wire [8:0] top_char = fifo_mem[rd_ptr_reg];
	wire [7:0] rsc_view = {rsc_reg[7:4], 2'b00, overrun_reg, top_char[8] & receive_complete_flag};
	wire [7:0] tsc_view = {tsc_reg[7:2], ~tsr_busy_reg, tsc_reg[0]};
	wire [7:0] int_view = {2'b00, transmit_buffer_free_flag, receive_complete_flag, int_ctl_reg[3:0]};
	wire rx_done = trail_edge & rx_on & (rx_bits_reg == rx_len - 4'h1);
	wire tx_done = trail_edge & tx_mode & tsr_busy_reg & (tx_bits_reg == tx_len - 4'h1);
	wire [7:0] rsc_wr = writedata[7:0] & `RSC_WRITE_MASK;

	// read data is staged in the wait cycle so it stands at the accepting edge
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			readdata <= 32'h00000000;
		end else begin
			ack_reg <= bus_req & ~ack_reg;
			if (read & ~ack_reg) begin
				case (address)
				`ADDR_TX_STATUS_CONTROL: readdata <= {24'h000000, tsc_view};
				`ADDR_RX_STATUS_CONTROL: readdata <= {24'h000000, rsc_view};
				`ADDR_BAUD_CONTROL: readdata <= {24'h000000, baud_ctl_reg};
				`ADDR_BAUD_DIVISOR_LOW: readdata <= {24'h000000, div_low_reg};
				`ADDR_BAUD_DIVISOR_HIGH: readdata <= {24'h000000, div_high_reg};
				`ADDR_RECEIVE_DATA: readdata <= {24'h000000, top_char[7:0]};
				`ADDR_INTERRUPT_CONTROL: readdata <= {24'h000000, int_view};
				default: readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// control registers and the serial engine; port off resets the engine
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tsc_reg <= `CONTROL_RESET;
			rsc_reg <= `CONTROL_RESET;
			baud_ctl_reg <= `CONTROL_RESET;
			div_low_reg <= `CONTROL_RESET;
			div_high_reg <= `CONTROL_RESET;
			int_ctl_reg <= `CONTROL_RESET;
			overrun_reg <= 1'b0;
			fifo_mem[0] <= 9'h000;
			fifo_mem[1] <= 9'h000;
			rd_ptr_reg <= 1'b0;
			fifo_count_reg <= 2'b00;
			rsr_reg <= 9'h000;
			rx_bits_reg <= 4'h0;
			tx_buf_reg <= `TRANSMIT_BUFFER_RESET;
			tx_buf_full_reg <= 1'b0;
			tsr_reg <= 9'h000;
			tsr_busy_reg <= 1'b0;
			tx_first_reg <= 1'b0;
			tx_bits_reg <= 4'h0;
		end else begin
			// plain register writes
			if (wr_take) begin
				case (address)
				`ADDR_TX_STATUS_CONTROL: tsc_reg <= writedata[7:0] & `TSC_WRITE_MASK;
				`ADDR_BAUD_CONTROL: baud_ctl_reg <= writedata[7:0] & `BAUD_WRITE_MASK;
				`ADDR_BAUD_DIVISOR_LOW: div_low_reg <= writedata[7:0];
				`ADDR_BAUD_DIVISOR_HIGH: div_high_reg <= writedata[7:0];
				`ADDR_INTERRUPT_CONTROL: int_ctl_reg <= writedata[7:0] & `INT_WRITE_MASK;
				default: tsc_reg <= tsc_reg;
				endcase
			end
			// receive control: software write, else single enable self-clears
			if (wr_rsc) begin
				rsc_reg <= rsc_wr;
			end else if (rx_done) begin
				rsc_reg[`RSC_SINGLE_RX_ENABLE] <= 1'b0;
			end
			// overrun: a new overrun wins over any clear in the same cycle
			if (rx_done & fifo_count_reg[1]) begin
				overrun_reg <= 1'b1;
			end else if (!port_on) begin
				overrun_reg <= 1'b0;
			end else if (wr_rsc & ~rsc_wr[`RSC_CONTINUOUS_RX_ENABLE] & continuous_receive_enable) begin
				overrun_reg <= 1'b0;
			end else if (rd_pop & single_receive_enable & ~continuous_receive_enable) begin
				overrun_reg <= 1'b0;
			end
			// receive shifter: bits dropped whenever reception is off
			if (!rx_on | !(master_mode | slave_mode)) begin
				rx_bits_reg <= 4'h0; // partial character discarded
			end else if (trail_edge) begin
				rsr_reg <= {pin_data_s, rsr_reg[8:1]};
				rx_bits_reg <= rx_done ? 4'h0 : rx_bits_reg + 4'h1;
			end
			// receive buffer; a full buffer keeps its contents
			if (!port_on) begin
				fifo_count_reg <= 2'b00;
				rd_ptr_reg <= 1'b0;
			end else begin
				if (rx_done & ~fifo_count_reg[1]) begin
					fifo_mem[rd_ptr_reg ^ fifo_count_reg[0]] <= (rx_len == `CHAR_BITS_LONG) ?
						{pin_data_s, rsr_reg[8:1]} : {1'b0, pin_data_s, rsr_reg[8:2]};
				end
				if (rd_pop) begin
					rd_ptr_reg <= ~rd_ptr_reg;
				end
				case ({rx_done & ~fifo_count_reg[1], rd_pop})
				2'b10: fifo_count_reg <= fifo_count_reg + 2'b01;
				2'b01: fifo_count_reg <= fifo_count_reg - 2'b01;
				default: fifo_count_reg <= fifo_count_reg;
				endcase
			end
			// transmit buffer and shift register
			if (!port_on) begin
				tx_buf_full_reg <= 1'b0;
				tsr_busy_reg <= 1'b0;
				tx_bits_reg <= 4'h0;
			end else begin
				if (wr_tx & ~tx_buf_full_reg) begin
					tx_buf_reg <= {tsc_reg[`TSC_TRANSMIT_NINTH_BIT], writedata[7:0]};
					tx_buf_full_reg <= 1'b1;
				end else if (tx_buf_full_reg & (~tsr_busy_reg | tx_done)) begin
					// move waiting character in; free flag follows the move
					tsr_reg <= tx_buf_reg;
					tsr_busy_reg <= 1'b1;
					tx_first_reg <= 1'b1;
					tx_bits_reg <= 4'h0;
					tx_buf_full_reg <= 1'b0;
				end
				if (!(tx_buf_full_reg & (~tsr_busy_reg | tx_done)) | (wr_tx & ~tx_buf_full_reg)) begin
					if (tx_done) begin
						tsr_busy_reg <= 1'b0;
					end else if (tsr_busy_reg & tx_mode & trail_edge) begin
						tx_bits_reg <= tx_bits_reg + 4'h1;
					end else if (tsr_busy_reg & tx_mode & lead_edge) begin
						// bit 0 is already out; later bits change on the leading edge
						if (tx_first_reg) begin
							tx_first_reg <= 1'b0;
						end else begin
							tsr_reg <= {1'b0, tsr_reg[8:1]};
						end
					end
				end
			end
		end
	end

	// pins: clock driven only as master, data driven only while transmitting
	assign shift_clock_pin_out = mclk_reg;
	assign shift_clock_pin_oe_n = ~master_mode;
	assign shift_data_pin_out = tsr_reg[0];
	assign shift_data_pin_oe_n = ~(port_on & sync_sel & tx_mode);

	// event requests toward the core's interrupt controller
	assign receive_request = receive_complete_flag & int_ctl_reg[`INT_RECEIVE_ENABLE];
	assign wake_request = receive_request | (transmit_buffer_free_flag & int_ctl_reg[`INT_TRANSMIT_ENABLE] &
		int_ctl_reg[`INT_PERIPHERAL_ENABLE]);
	assign vector_request = wake_request & int_ctl_reg[`INT_GLOBAL_ENABLE];
endmodule

// *** sync_serial_master_rx_slave_tx_bench.sv ***
`timescale 1ns/1ps
`include "sync_serial_consts.vh"
module sync_serial_master_rx_slave_tx_bench;
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg read = 1'b0;
	reg write = 1'b0;
	reg core_sleep = 1'b0;
	reg [5:0] address = 6'h00;
	reg [31:0] writedata = 32'h00000000;
	reg [31:0] seen;
	reg [21:0] rows [0:4];
	wire [31:0] readdata;
	wire waitrequest, clk_out, clk_oe_n, data_out, data_oe_n, rx_req, wake, vec;
	wire clk_drive, data_drive, data_en;
	// the device owns each wire while its driver is enabled; otherwise the far side drives it, data_en unused
	wire clk_line = clk_oe_n ? clk_drive : clk_out;
	wire data_line = data_oe_n ? data_drive : data_out; // plain digital pin, no analog
	integer miscompares = 0;
	integer checks = 0;
	integer edges = 0;
	integer i;
	always #2.5 core_clk = ~core_clk;
	// generated clock pulses
	always @(posedge clk_out) edges = edges + 1;
	sync_serial_master_rx_slave_tx sync_serial_master_rx_slave_tx_inst (
		.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.shift_clock_pin_in(clk_line), .shift_clock_pin_out(clk_out),
		.shift_clock_pin_oe_n(clk_oe_n), .shift_data_pin_in(data_line),
		.shift_data_pin_out(data_out), .shift_data_pin_oe_n(data_oe_n), .core_sleep(core_sleep),
		.receive_request(rx_req), .wake_request(wake), .vector_request(vec)
	);
	far_side_model far_side_model_inst (
		.clk_line(clk_line), .data_line(data_line), .clk_drive(clk_drive),
		.data_drive(data_drive), .data_en(data_en)
	);
	task check(input string name, input [31:0] got, input [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	// request held until waitrequest is sampled low
	task bus(input is_read, input [5:0] a, input [7:0] d);
		@(posedge core_clk);
		address <= a;
		writedata <= {24'h000000, d};
		read <= is_read;
		write <= !is_read;
		@(posedge core_clk);
		while (waitrequest) @(posedge core_clk);
		seen = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task close_out;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// tests need about 1100 cycles; ample slack
	initial begin
		#30000;
		miscompares = miscompares + 1;
		close_out;
	end
	initial begin
		rows[0] = {`ADDR_BAUD_DIVISOR_HIGH, 8'h5A, 8'h5A};
		rows[1] = {`ADDR_BAUD_DIVISOR_HIGH, 8'h00, 8'h00};
		rows[2] = {`ADDR_BAUD_DIVISOR_LOW, 8'h03, 8'h03};
		rows[3] = {`ADDR_BAUD_CONTROL, 8'hFF, 8'h08};
		rows[4] = {6'h3C, 8'hFF, 8'h00};
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		// write then read back; half period ends as 4 cycles
		for (i = 0; i < 5; i = i + 1) begin
			bus(0, rows[i][21:16], rows[i][15:8]);
			bus(1, rows[i][21:16], 8'h00);
			check("row", seen, {24'h000000, rows[i][7:0]});
		end
		$display("rows done");
		bus(0, `ADDR_INTERRUPT_CONTROL, 8'h01);
		bus(0, `ADDR_TX_STATUS_CONTROL, 8'h90);
		bus(0, `ADDR_RX_STATUS_CONTROL, 8'h80);
		far_side_model_inst.load(24'h0000C3);
		edges = 0;
		bus(0, `ADDR_RX_STATUS_CONTROL, 8'hA0);
		for (i = 0; i < 400 && rx_req !== 1'b1; i = i + 1) @(posedge core_clk);
		check("clock oe", clk_oe_n, 0);
		check("pulses", edges, 8);
		check("rx req", rx_req, 1);
		bus(1, `ADDR_RX_STATUS_CONTROL, 8'h00);
		check("rx status", seen, 32'h00000080);
		bus(1, `ADDR_RECEIVE_DATA, 8'h00);
		check("rx data", seen, 32'h000000C3);
		@(posedge core_clk);
		check("rx req", rx_req, 0);
		$display("single done");
		// third character overruns; fixed wait from the half period
		far_side_model_inst.load(24'h3396C3);
		bus(0, `ADDR_RX_STATUS_CONTROL, 8'h90);
		repeat (300) @(posedge core_clk);
		bus(1, `ADDR_RX_STATUS_CONTROL, 8'h00);
		check("overrun", seen, 32'h00000092);
		bus(1, `ADDR_RECEIVE_DATA, 8'h00);
		check("kept 1", seen, 32'h000000C3);
		bus(1, `ADDR_RECEIVE_DATA, 8'h00);
		check("kept 2", seen, 32'h00000096);
		bus(0, `ADDR_RX_STATUS_CONTROL, 8'h80);
		bus(1, `ADDR_RX_STATUS_CONTROL, 8'h00);
		check("cleared", seen, 32'h00000080);
		// nine-bit single character, ninth bit set
		far_side_model_inst.load(24'h0001A5);
		bus(0, `ADDR_RX_STATUS_CONTROL, 8'hE0);
		for (i = 0; i < 400 && rx_req !== 1'b1; i = i + 1) @(posedge core_clk);
		bus(1, `ADDR_RX_STATUS_CONTROL, 8'h00);
		check("ninth", seen, 32'h000000C1);
		bus(1, `ADDR_RECEIVE_DATA, 8'h00);
		check("nine data", seen, 32'h000000A5);
		$display("nine bit done");
		far_side_model_inst.release_data;
		$display("overrun done");
		bus(0, `ADDR_RX_STATUS_CONTROL, 8'h00);
		bus(0, `ADDR_TX_STATUS_CONTROL, 8'h30);
		bus(0, `ADDR_RX_STATUS_CONTROL, 8'h80);
		bus(0, `ADDR_INTERRUPT_CONTROL, 8'h06);
		check("clock oe", clk_oe_n, 1);
		check("data oe", data_oe_n, 0);
		bus(0, `ADDR_TRANSMIT_DATA, 8'hA5);
		bus(0, `ADDR_TRANSMIT_DATA, 8'h3C);
		core_sleep <= 1'b1;
		bus(1, `ADDR_INTERRUPT_CONTROL, 8'h00);
		check("free", seen & 32'h00000020, 0);
		check("wake", wake, 0);
		far_side_model_inst.clock_frame(8);
		check("out 1", far_side_model_inst.rx_shift[8:1], 8'hA5);
		for (i = 0; i < 100 && wake !== 1'b1; i = i + 1) @(posedge core_clk);
		check("wake", wake, 1);
		check("vector", vec, 0);
		core_sleep <= 1'b0;
		bus(0, `ADDR_INTERRUPT_CONTROL, 8'h0E);
		@(posedge core_clk);
		check("vector", vec, 1);
		far_side_model_inst.clock_frame(8);
		check("out 2", far_side_model_inst.rx_shift[8:1], 8'h3C);
		$display("slave done");
		close_out;
	end
endmodule

// *** sync_two_flop.v ***
`timescale 1ns/1ps

// two-flop synchroniser for pin inputs; only the second stage leaves
module sync_two_flop #(
	parameter WIDTH = 2
) (
	input wire core_clk,
	input wire rst_n,
	input wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;

	// metastability settles in the first stage
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_reg <= {WIDTH{1'b0}};
			stage2_reg <= {WIDTH{1'b0}};
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;
endmodule
